// ---- hw/bmm_pkg.sv ----
// Shared constants and types for the memory command layer and its master
// Overview of operation
// - Copy page moves scratchpad page into memory
// - Nonvolatile busy flag high during copy
// - Status read slots answer 0 busy, 1 done
// - Recall loads memory page into scratchpad
// - Temperature command starts conversion at once
// - Temperature busy flag high while converting
// - Temperature status reads 0 busy, 1 done
// - Voltage command starts conversion, sets busy
// - Input select bit chooses converted voltage
// - Voltage done clears busy, stores page0 result
// - Other commands still run during voltage conversion
// - Voltage status reads 0 busy, 1 done
// - Temperature conversion ends within 10 ms
// - Voltage conversion ends within 4 ms
// - Copy finishes within 10 ms
// - Scratchpad read gives eight bytes then CRC
// - Scratchpad write stores up to eight bytes
// - Config byte write enables accumulators immediately
// - Page zero holds measurement results
// - Reserved bits and bytes past CRC read ones
// - Write starts at byte zero, reset ends
package bmm_pkg;
  localparam int CLK_HZ  = 20_000_000;
  localparam int TEMP_MS = 10;
  localparam int ADC_MS  = 4;
  localparam int COPY_MS = 10;
  localparam int TEMP_CYC_N = CLK_HZ / 1000 * TEMP_MS;
  localparam int ADC_CYC_N  = CLK_HZ / 1000 * ADC_MS;
  localparam int COPY_CYC_N = CLK_HZ / 1000 * COPY_MS;
  localparam logic [17:0] TEMP_CYC = 18'(TEMP_CYC_N);
  localparam logic [17:0] ADC_CYC  = 18'(ADC_CYC_N);
  localparam logic [17:0] COPY_CYC = 18'(COPY_CYC_N);

  localparam logic [7:0] CMD_WRITE_SP = 8'h4E;
  localparam logic [7:0] CMD_READ_SP  = 8'hBE;
  localparam logic [7:0] CMD_COPY_SP  = 8'h48;
  localparam logic [7:0] CMD_RECALL   = 8'hB8;
  localparam logic [7:0] CMD_CONV_T   = 8'h44;
  localparam logic [7:0] CMD_CONV_V   = 8'hB4;
  localparam logic [7:0] PAGE_LAST    = 8'h07;
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;
  localparam logic [7:0] BUSY_BYTE    = 8'h00;
  localparam logic [7:0] CRC_POLY     = 8'h8C;
  localparam logic [3:0] PAGE_BYTES   = 4'h8;
  localparam logic [3:0] CRC_IDX      = 4'h8;
  localparam logic [3:0] END_IDX      = 4'h9;

  // Page zero layout, bit positions of the status/config byte
  localparam int BIT_CUR_ACC  = 0;
  localparam int BIT_CHG_ACC  = 1;
  localparam int BIT_SHADOW   = 2;
  localparam int BIT_AD_SEL   = 3;
  localparam int BIT_TEMP_BSY = 4;
  localparam int BIT_NV_BSY   = 5;
  localparam int BIT_ADC_BSY  = 6;
  localparam int BIT_RSVD     = 7;
  localparam int OFS_TEMP     = 8;
  localparam int OFS_VOLT     = 24;
  localparam int OFS_CURR     = 40;

  typedef enum logic [1:0] {POLL_TEMP, POLL_ADC, POLL_NV} bmm_poll_type;
endpackage : bmm_pkg

// ---- hw/bmm_link_if.sv ----
// Byte-level link between the bus master and the memory command layer
`timescale 1ns/1ps
interface bmm_link_if;
  logic       bus_rst;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       rx_req;
  logic       rx_valid;
  logic [7:0] rx_data;

  modport host (
    output bus_rst,
    output tx_valid,
    output tx_data,
    output rx_req,
    input  rx_valid,
    input  rx_data
  );
  modport dev (
    input  bus_rst,
    input  tx_valid,
    input  tx_data,
    input  rx_req,
    output rx_valid,
    output rx_data
  );
endinterface : bmm_link_if

// ---- hw/bmm_dev.sv ----
// Device end: memory and conversion command interpreter
`timescale 1ns/1ps
module bmm_dev #(
  parameter logic [17:0] TEMP_CYC = bmm_pkg::TEMP_CYC,
  parameter logic [17:0] ADC_CYC  = bmm_pkg::ADC_CYC,
  parameter logic [17:0] COPY_CYC = bmm_pkg::COPY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  bmm_link_if.dev          link,
  input  wire logic [15:0] temp_result_i,
  input  wire logic [15:0] volt_vdd_i,
  input  wire logic [15:0] volt_aux_i,
  input  wire logic [15:0] current_i,
  output logic             temperature_busy_flag_o,
  output logic             adc_busy_flag_o,
  output logic             nonvolatile_busy_flag_o,
  output logic             integrated_current_accumulator_o,
  output logic             charge_accumulator_enable_o,
  output logic             accumulator_shadow_enable_o,
  output logic             adc_sel_vdd_o
);
  import bmm_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_CMD, S_PAGE, S_WRITE, S_READ, S_STATUS, S_IGNORE
  } bmm_dev_state_type;

  typedef struct packed {
    bmm_dev_state_type st;
    logic [7:0]        cmd;
    logic [2:0]        page;
    logic [3:0]        idx;
    bmm_poll_type      poll;
    logic [7:0][63:0]  sp;
    logic [7:0][63:0]  mem;
    logic [17:0]       t_cnt;
    logic [17:0]       a_cnt;
    logic [17:0]       c_cnt;
    logic              t_bsy;
    logic              a_bsy;
    logic              c_bsy;
    logic              rx_valid;
    logic [7:0]        rx_data;
  } bmm_dev_reg_type;

  bmm_dev_reg_type r_ff;
  bmm_dev_reg_type nxt_r;

  // ---------------------------------------------------------------
  // CRC over one page, least significant bit first
  // ---------------------------------------------------------------
  function automatic logic [7:0] bmm_crc8(input logic [63:0] d);
    logic [7:0] c;
    logic       fb;
    c  = 8'h00;
    fb = 1'b0;
    for (int i = 0; i < 64; i++) begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[7:1]};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : bmm_crc8

  logic [7:0] cfg_byte;
  logic [7:0] rd_byte;
  logic       poll_busy;

  always_comb begin
    // Busy bits are live, reserved bit always reads one
    cfg_byte = r_ff.mem[0][7:0];
    cfg_byte[BIT_TEMP_BSY] = r_ff.t_bsy;
    cfg_byte[BIT_NV_BSY]   = r_ff.c_bsy;
    cfg_byte[BIT_ADC_BSY]  = r_ff.a_bsy;
    cfg_byte[BIT_RSVD]     = 1'b1;
    if (r_ff.idx == CRC_IDX) begin
      rd_byte = bmm_crc8(r_ff.sp[r_ff.page]);
    end else if (r_ff.idx > CRC_IDX) begin
      rd_byte = IDLE_BYTE;
    end else if (r_ff.page == 3'd0 && r_ff.idx == 4'd0) begin
      rd_byte = cfg_byte;
    end else begin
      rd_byte = r_ff.sp[r_ff.page][{r_ff.idx[2:0], 3'b000} +: 8];
    end
    case (r_ff.poll)
      POLL_TEMP: poll_busy = r_ff.t_bsy;
      POLL_ADC:  poll_busy = r_ff.a_bsy;
      POLL_NV:   poll_busy = r_ff.c_bsy;
      default:   poll_busy = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rx_valid = 1'b0;

    // Timers run on regardless of the command state
    if (r_ff.t_cnt != 18'd0) begin
      nxt_r.t_cnt = r_ff.t_cnt - 18'd1;
      if (r_ff.t_cnt == 18'd1) begin
        nxt_r.t_bsy = 1'b0;
        nxt_r.mem[0][OFS_TEMP +: 16] = temp_result_i;
      end
    end
    if (r_ff.a_cnt != 18'd0) begin
      nxt_r.a_cnt = r_ff.a_cnt - 18'd1;
      if (r_ff.a_cnt == 18'd1) begin
        nxt_r.a_bsy = 1'b0;
        if (r_ff.mem[0][BIT_AD_SEL]) begin
          nxt_r.mem[0][OFS_VOLT +: 16] = volt_vdd_i;
        end else begin
          nxt_r.mem[0][OFS_VOLT +: 16] = volt_aux_i;
        end
      end
    end
    if (r_ff.c_cnt != 18'd0) begin
      nxt_r.c_cnt = r_ff.c_cnt - 18'd1;
      if (r_ff.c_cnt == 18'd1) begin
        nxt_r.c_bsy = 1'b0;
      end
    end

    // Read slots: one answer byte the cycle after each request
    if (link.rx_req) begin
      nxt_r.rx_valid = 1'b1;
      case (r_ff.st)
        S_READ: begin
          nxt_r.rx_data = rd_byte;
          if (r_ff.idx != END_IDX) begin
            nxt_r.idx = r_ff.idx + 4'd1;
          end
        end
        S_STATUS: begin
          nxt_r.rx_data = poll_busy ? BUSY_BYTE : IDLE_BYTE;
        end
        default:  nxt_r.rx_data = IDLE_BYTE;
      endcase
    end

    if (link.tx_valid) begin
      case (r_ff.st)
        S_CMD: begin
          nxt_r.cmd = link.tx_data;
          case (link.tx_data)
            CMD_CONV_T: begin
              nxt_r.t_cnt = TEMP_CYC;
              nxt_r.t_bsy = 1'b1;
              nxt_r.poll  = POLL_TEMP;
              nxt_r.st    = S_STATUS;
            end
            CMD_CONV_V: begin
              nxt_r.a_cnt = ADC_CYC;
              nxt_r.a_bsy = 1'b1;
              nxt_r.poll  = POLL_ADC;
              nxt_r.st    = S_STATUS;
            end
            CMD_WRITE_SP, CMD_READ_SP, CMD_COPY_SP, CMD_RECALL: begin
              nxt_r.st = S_PAGE;
            end
            default: nxt_r.st = S_IGNORE;
          endcase
        end
        S_PAGE: begin
          nxt_r.page = link.tx_data[2:0];
          nxt_r.idx  = 4'd0;
          if (link.tx_data > PAGE_LAST) begin
            nxt_r.st = S_IGNORE;
          end else begin
            case (r_ff.cmd)
              CMD_WRITE_SP: nxt_r.st = S_WRITE;
              CMD_READ_SP:  nxt_r.st = S_READ;
              CMD_COPY_SP: begin
                // Page lands at once; busy models the write time only
                nxt_r.mem[link.tx_data[2:0]] =
                  r_ff.sp[link.tx_data[2:0]];
                nxt_r.c_cnt = COPY_CYC;
                nxt_r.c_bsy = 1'b1;
                nxt_r.poll  = POLL_NV;
                nxt_r.st    = S_STATUS;
              end
              default: begin
                nxt_r.sp[link.tx_data[2:0]] =
                  r_ff.mem[link.tx_data[2:0]];
                if (link.tx_data[2:0] == 3'd0) begin
                  nxt_r.sp[0][OFS_CURR +: 16] = current_i;
                end
                nxt_r.st = S_IGNORE;
              end
            endcase
          end
        end
        S_WRITE: begin
          if (r_ff.idx < PAGE_BYTES) begin
            nxt_r.sp[r_ff.page][{r_ff.idx[2:0], 3'b000} +: 8] =
              link.tx_data;
            nxt_r.idx = r_ff.idx + 4'd1;
            if (r_ff.page == 3'd0 && r_ff.idx == 4'd0) begin
              // Config takes effect without a copy
              nxt_r.mem[0][3:0] = link.tx_data[3:0];
            end
          end
        end
        default: nxt_r.st = r_ff.st;
      endcase
    end

    // Conversions and copy keep running across a bus reset
    if (link.bus_rst) begin
      nxt_r.st  = S_CMD;
      nxt_r.idx = 4'd0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.rx_valid = r_ff.rx_valid;
  assign link.rx_data  = r_ff.rx_data;
  assign temperature_busy_flag_o          = r_ff.t_bsy;
  assign adc_busy_flag_o                  = r_ff.a_bsy;
  assign nonvolatile_busy_flag_o          = r_ff.c_bsy;
  assign integrated_current_accumulator_o = r_ff.mem[0][BIT_CUR_ACC];
  assign charge_accumulator_enable_o      = r_ff.mem[0][BIT_CHG_ACC];
  assign accumulator_shadow_enable_o      = r_ff.mem[0][BIT_SHADOW];
  assign adc_sel_vdd_o                    = r_ff.mem[0][BIT_AD_SEL];
endmodule : bmm_dev

// ---- hw/bmm_host.sv ----
// Master end: runs one memory or conversion command per request
`timescale 1ns/1ps
module bmm_host (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  bmm_link_if.host         link,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [7:0]  cmd_page_i,
  input  wire logic [63:0] wr_data_i,
  input  wire logic [3:0]  len_i,
  output logic             cmd_ready_o,
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o,
  output logic             done_o
);
  import bmm_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE, H_RST, H_CMD, H_PAGE, H_WR, H_RD, H_POLL, H_FIN
  } bmm_host_state_type;

  typedef struct packed {
    bmm_host_state_type st;
    logic [7:0]         code;
    logic [7:0]         page;
    logic [63:0]        wdat;
    logic [3:0]         len;
    logic [3:0]         cnt;
    logic               pend;
    logic               bus_rst;
    logic               tx_valid;
    logic [7:0]         tx_data;
    logic               rx_req;
    logic               ready;
    logic               rd_valid;
    logic [7:0]         rd_data;
    logic               done;
  } bmm_host_reg_type;

  bmm_host_reg_type r_ff;
  bmm_host_reg_type nxt_r;
  logic             paged;

  always_comb begin
    paged = (r_ff.code == CMD_WRITE_SP) || (r_ff.code == CMD_READ_SP) ||
            (r_ff.code == CMD_COPY_SP)  || (r_ff.code == CMD_RECALL);
    nxt_r = r_ff;
    nxt_r.bus_rst  = 1'b0;
    nxt_r.tx_valid = 1'b0;
    nxt_r.rx_req   = 1'b0;
    nxt_r.rd_valid = 1'b0;
    nxt_r.done     = 1'b0;
    case (r_ff.st)
      H_IDLE: begin
        if (cmd_valid_i) begin
          nxt_r.code  = cmd_code_i;
          nxt_r.page  = cmd_page_i;
          nxt_r.wdat  = wr_data_i;
          nxt_r.len   = len_i;
          nxt_r.ready = 1'b0;
          nxt_r.st    = H_RST;
        end
      end
      H_RST: begin
        nxt_r.bus_rst = 1'b1;
        nxt_r.st      = H_CMD;
      end
      H_CMD: begin
        nxt_r.tx_valid = 1'b1;
        nxt_r.tx_data  = r_ff.code;
        if (paged) begin
          nxt_r.st = H_PAGE;
        end else if (r_ff.code == CMD_CONV_T || r_ff.code == CMD_CONV_V) begin
          nxt_r.st = H_POLL;
        end else begin
          nxt_r.st = H_FIN;
        end
      end
      H_PAGE: begin
        nxt_r.tx_valid = 1'b1;
        nxt_r.tx_data  = r_ff.page;
        nxt_r.cnt      = 4'd0;
        if (r_ff.code == CMD_COPY_SP) begin
          nxt_r.st = H_POLL;
        end else if (r_ff.len == 4'd0) begin
          nxt_r.st = H_FIN;
        end else if (r_ff.code == CMD_WRITE_SP) begin
          nxt_r.st = H_WR;
        end else if (r_ff.code == CMD_READ_SP) begin
          nxt_r.st = H_RD;
        end else begin
          nxt_r.st = H_FIN;
        end
      end
      H_WR: begin
        nxt_r.tx_valid = 1'b1;
        nxt_r.tx_data  = r_ff.wdat[{r_ff.cnt[2:0], 3'b000} +: 8];
        nxt_r.cnt      = r_ff.cnt + 4'd1;
        if (r_ff.cnt + 4'd1 >= r_ff.len || r_ff.cnt == 4'd7) begin
          nxt_r.st = H_FIN;
        end
      end
      H_RD, H_POLL: begin
        if (!r_ff.pend) begin
          nxt_r.rx_req = 1'b1;
          nxt_r.pend   = 1'b1;
        end else if (link.rx_valid) begin
          nxt_r.pend = 1'b0;
          nxt_r.cnt  = r_ff.cnt + 4'd1;
          if (r_ff.st == H_RD) begin
            nxt_r.rd_valid = 1'b1;
            nxt_r.rd_data  = link.rx_data;
            if (r_ff.cnt + 4'd1 >= r_ff.len || r_ff.cnt == 4'd15) begin
              nxt_r.st = H_FIN;
            end
          end else if (link.rx_data == IDLE_BYTE) begin
            nxt_r.st = H_FIN;
          end
        end
      end
      H_FIN: begin
        nxt_r.done  = 1'b1;
        nxt_r.ready = 1'b1;
        nxt_r.st    = H_IDLE;
      end
      default: nxt_r.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_ff       <= '0;
      r_ff.ready <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign link.bus_rst  = r_ff.bus_rst;
  assign link.tx_valid = r_ff.tx_valid;
  assign link.tx_data  = r_ff.tx_data;
  assign link.rx_req   = r_ff.rx_req;
  assign cmd_ready_o   = r_ff.ready;
  assign rd_valid_o    = r_ff.rd_valid;
  assign rd_data_o     = r_ff.rd_data;
  assign done_o        = r_ff.done;
endmodule : bmm_host

// ---- verif/bmm_link_asserts.sv ----
// Checker for the byte link between master end and device end
`timescale 1ns/1ps
module bmm_link_asserts
  import bmm_pkg::*;
#(
  parameter int TEMP_N = 20,
  parameter int ADC_N  = 10,
  parameter int COPY_N = 15
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       bus_rst,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       rx_req,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       temperature_busy_flag_o,
  input wire logic       adc_busy_flag_o,
  input wire logic       nonvolatile_busy_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [17:0] tcnt_ff, acnt_ff, ncnt_ff;
  logic [1:0]  step_ff;
  logic        bad_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {tcnt_ff, acnt_ff, ncnt_ff, step_ff, bad_ff} <= '0;
    end else begin
      tcnt_ff <= temperature_busy_flag_o ? tcnt_ff + 18'h1 : 18'h0;
      acnt_ff <= adc_busy_flag_o ? acnt_ff + 18'h1 : 18'h0;
      ncnt_ff <= nonvolatile_busy_flag_o ? ncnt_ff + 18'h1 : 18'h0;
      // Page byte is the second byte after a bus reset
      if (bus_rst) begin
        step_ff <= 2'h1;
        bad_ff  <= 1'b0;
      end else if (tx_valid && step_ff != 2'h0 && step_ff != 2'h3) begin
        step_ff <= step_ff + 2'h1;
        if (step_ff == 2'h2) bad_ff <= tx_data > PAGE_LAST;
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_cmd(logic [7:0] c);
    bus_rst ##1 (tx_valid && tx_data == c);
  endsequence
  sequence s_copy_ok;
    s_cmd(CMD_COPY_SP) ##1 (tx_valid && tx_data <= PAGE_LAST);
  endsequence

  chk_rx_answer: assert property (rx_req |=> rx_valid)
    else $error("read request not answered next cycle");
  chk_rx_cause: assert property (rx_valid |-> $past(rx_req))
    else $error("answer without a read request");
  chk_rx_hold: assert property (!rx_valid |-> $stable(rx_data))
    else $error("answer byte changed without a new answer");
  chk_temp_start: assert property (
      s_cmd(CMD_CONV_T) |=> temperature_busy_flag_o)
    else $error("temperature busy not set after command");
  chk_temp_len: assert property (
      $fell(temperature_busy_flag_o) |-> tcnt_ff == 18'(TEMP_N))
    else $error("temperature busy length wrong");
  chk_adc_start: assert property (s_cmd(CMD_CONV_V) |=> adc_busy_flag_o)
    else $error("voltage busy not set after command");
  chk_adc_len: assert property (
      $fell(adc_busy_flag_o) |-> acnt_ff == 18'(ADC_N))
    else $error("voltage busy length wrong");
  chk_copy_start: assert property (
      s_copy_ok |=> nonvolatile_busy_flag_o)
    else $error("copy busy not set after page byte");
  chk_copy_len: assert property (
      $fell(nonvolatile_busy_flag_o) |-> ncnt_ff == 18'(COPY_N))
    else $error("copy busy length wrong");
  chk_bad_page: assert property (
      rx_valid && bad_ff |-> rx_data == IDLE_BYTE)
    else $error("bad page did not return idle data");
endmodule : bmm_link_asserts

// ---- verif/battery_monitor_memory_commands_tb.sv ----
// Testbench joining master end and device end
`timescale 1ns/1ps
module battery_monitor_memory_commands_tb;
  import bmm_pkg::*;
  localparam int TN = 20;
  localparam int AN = 10;
  localparam int CN = 15;
  logic        clk_i         = 1'b0;
  logic        rst_n_i       = 1'b0;
  logic        cmd_valid_i   = 1'b0;
  logic [7:0]  cmd_code_i    = 8'h00;
  logic [7:0]  cmd_page_i    = 8'h00;
  logic [63:0] wr_data_i     = 64'h0;
  logic [3:0]  len_i         = 4'h0;
  logic [15:0] temp_result_i = 16'h1A2B;
  logic [15:0] volt_vdd_i    = 16'h0345;
  logic [15:0] volt_aux_i    = 16'h0123;
  logic [15:0] current_i     = 16'hFE10;
  logic        cmd_ready_o, rd_valid_o, done_o;
  logic [7:0]  rd_data_o;
  logic        tflag, aflag, nflag, integrated_current_accumulator, cae, sha, sel;
  logic [7:0]  rbuf [16];
  int          err_total = 0;
  int          tests_run = 0;
  int          nrd;
  int          nbusy;
  int          bcnt [3];

  bmm_link_if bmm_link_if_i ();
  bmm_dev #(
    .TEMP_CYC(18'(TN)),
    .ADC_CYC (18'(AN)),
    .COPY_CYC(18'(CN))
  ) bmm_dev_i (
    .clk_i, .rst_n_i, .link(bmm_link_if_i), .temp_result_i, .volt_vdd_i,
    .volt_aux_i, .current_i, .temperature_busy_flag_o(tflag),
    .adc_busy_flag_o(aflag), .nonvolatile_busy_flag_o(nflag),
    .integrated_current_accumulator_o(integrated_current_accumulator),
    .charge_accumulator_enable_o(cae), .accumulator_shadow_enable_o(sha),
    .adc_sel_vdd_o(sel));
  bmm_host bmm_host_i (
    .clk_i, .rst_n_i, .link(bmm_link_if_i), .cmd_valid_i, .cmd_code_i,
    .cmd_page_i, .wr_data_i, .len_i, .cmd_ready_o, .rd_valid_o, .rd_data_o,
    .done_o);
  bmm_link_asserts #(.TEMP_N(TN), .ADC_N(AN), .COPY_N(CN))
    bmm_link_asserts_i (
    .clk_i, .rst_n_i, .bus_rst(bmm_link_if_i.bus_rst),
    .tx_valid(bmm_link_if_i.tx_valid), .tx_data(bmm_link_if_i.tx_data),
    .rx_req(bmm_link_if_i.rx_req), .rx_valid(bmm_link_if_i.rx_valid),
    .rx_data(bmm_link_if_i.rx_data), .temperature_busy_flag_o(tflag),
    .adc_busy_flag_o(aflag), .nonvolatile_busy_flag_o(nflag));

  always #25 clk_i = ~clk_i;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // One command through the master end; collects bytes and busy times
  task automatic run_cmd(input logic [7:0] c, input logic [7:0] p,
                         input logic [63:0] d, input logic [3:0] n);
    int k;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_code_i  <= c;
    cmd_page_i  <= p;
    wr_data_i   <= d;
    len_i       <= n;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    nrd = 0;
    nbusy = 0;
    bcnt = '{0, 0, 0};
    for (k = 0; k < 3000; k++) begin
      @(posedge clk_i);
      #1;
      if (rd_valid_o === 1'b1 && nrd < 16) begin
        rbuf[nrd] = rd_data_o;
        nrd++;
      end
      // Status slot answers seen while a job is still running
      if (bmm_link_if_i.rx_valid === 1'b1 &&
          bmm_link_if_i.rx_data === BUSY_BYTE) nbusy++;
      if (tflag === 1'b1) bcnt[0]++;
      if (aflag === 1'b1) bcnt[1]++;
      if (nflag === 1'b1) bcnt[2]++;
      if (done_o === 1'b1) break;
    end
    if (k == 3000) check(1'b0, 1'b1);
    check(cmd_ready_o, 1'b1);
  endtask : run_cmd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_cfg();
    run_cmd(CMD_WRITE_SP, 8'h00, 64'h0F, 4'h1);
    check({integrated_current_accumulator, cae, sha, sel}, 4'hF);
    $display("t_cfg done");
  endtask : t_cfg

  task automatic t_temp();
    run_cmd(CMD_CONV_T, 8'h00, 64'h0, 4'h0);
    check(64'(bcnt[0]), 64'(TN));
    check(nbusy > 0, 1'b1);
    check(tflag, 1'b0);
    $display("t_temp done");
  endtask : t_temp

  task automatic t_volt(input logic [3:0] cfg, input logic [15:0] v);
    run_cmd(CMD_WRITE_SP, 8'h00, {60'h0, cfg}, 4'h1);
    check(sel, cfg[3]);
    run_cmd(CMD_CONV_V, 8'h00, 64'h0, 4'h0);
    check(64'(bcnt[1]), 64'(AN));
    check(nbusy > 0, 1'b1);
    run_cmd(CMD_RECALL, 8'h00, 64'h0, 4'h0);
    run_cmd(CMD_READ_SP, 8'h00, 64'h0, 4'h7);
    check(64'(nrd), 64'd7);
    check({rbuf[6], rbuf[5], rbuf[4], rbuf[3], rbuf[2], rbuf[1], rbuf[0]},
          {current_i, v, temp_result_i, 4'h8, cfg});
    $display("t_volt done");
  endtask : t_volt

  task automatic t_copy();
    logic [63:0] a;
    logic [63:0] got;
    logic [7:0]  crc;
    logic        fb;
    a = 64'h8877665544332211;
    run_cmd(CMD_WRITE_SP, 8'h03, a, 4'h8);
    run_cmd(CMD_COPY_SP, 8'h03, 64'h0, 4'h0);
    check(64'(bcnt[2]), 64'(CN));
    check(nbusy > 0, 1'b1);
    run_cmd(CMD_WRITE_SP, 8'h03, ~a, 4'h8);
    run_cmd(CMD_RECALL, 8'h03, 64'h0, 4'h0);
    run_cmd(CMD_READ_SP, 8'h03, 64'h0, 4'hA);
    check(64'(nrd), 64'd10);
    for (int i = 0; i < 8; i++) got[i*8 +: 8] = rbuf[i];
    check(got, a);
    crc = 8'h00;
    // Check byte built bit by bit, least significant first
    for (int i = 0; i < 64; i++) begin
      fb  = crc[0] ^ a[i];
      crc = (crc >> 1) ^ (fb ? 8'h8C : 8'h00);
    end
    check(rbuf[8], crc);
    check(rbuf[9], 8'hFF);
    $display("t_copy done");
  endtask : t_copy

  // Short write refills from byte zero and leaves the rest untouched
  task automatic t_trunc();
    run_cmd(CMD_WRITE_SP, 8'h05, 64'hFFEEDDCCBBAA9988, 4'h8);
    run_cmd(CMD_WRITE_SP, 8'h05, 64'h2211, 4'h2);
    run_cmd(CMD_READ_SP, 8'h05, 64'h0, 4'h8);
    check(64'(nrd), 64'd8);
    check({rbuf[7], rbuf[6], rbuf[5], rbuf[4], rbuf[3], rbuf[2], rbuf[1],
           rbuf[0]}, 64'hFFEEDDCCBBAA2211);
    $display("t_trunc done");
  endtask : t_trunc

  task automatic t_bad();
    run_cmd(CMD_READ_SP, 8'h08, 64'h0, 4'h2);
    check(64'(nrd), 64'd2);
    check({rbuf[1], rbuf[0]}, 16'hFFFF);
    $display("t_bad done");
  endtask : t_bad

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_cfg();
    t_temp();
    t_volt(4'hF, volt_vdd_i);
    t_volt(4'h7, volt_aux_i);
    t_copy();
    t_trunc();
    t_bad();
    summarize();
  end

  initial begin
    // Whole run needs well under a tenth of this
    #(50 * 40000);
    err_total++;
    summarize();
  end
endmodule : battery_monitor_memory_commands_tb
